/* compander_chk.sv */
`timescale 1ns/1ps
module compander_chk (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // watched ports
    input wire logic law_mu,
    input wire logic zero_sup,
    input wire logic path_alaw,
    input wire logic lin_in_take,
    input wire logic ser_tx,
    input wire logic ser_tx_frame,
    input wire logic ser_rx,
    input wire logic ser_rx_frame,
    input wire logic enc_valid,
    input wire logic enc_ready,
    input wire logic [7:0] enc_char,
    input wire logic dec_valid,
    input wire logic [7:0] dec_char
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // a refused strobe doubles the gap
    localparam logic [15:0] GAP1 = 16'(compander_pkg::SAMPLE_CYC - 1);
    localparam logic [15:0] GAP2 = 16'(2 * compander_pkg::SAMPLE_CYC - 1);
    // ----------------------------------------
    // helper state
    // ----------------------------------------
    logic [15:0] gap_r;
    logic seen_r;
    logic [1:0] occ_r;
    logic [3:0] rxn_r;
    logic [7:0] rxs_r;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            gap_r <= 16'h0000;
            seen_r <= 1'b0;
            occ_r <= 2'h0;
            rxn_r <= 4'h0;
        end else begin
            gap_r <= lin_in_take ? 16'h0000 : gap_r + 16'h0001;
            seen_r <= seen_r | lin_in_take;
            occ_r <= occ_r + 2'(lin_in_take) - 2'(enc_valid & enc_ready);
            rxn_r <= ser_rx_frame ? rxn_r + 4'h1 : 4'h0;
        end
        if (ser_rx_frame) begin
            rxs_r <= {rxs_r[6:0], ser_rx};
        end
    end
    chk_take_cadence: assert property (lin_in_take && seen_r |->
        gap_r == GAP1 || gap_r == GAP2) else $error("strobe cadence");
    chk_take_answer: assert property (lin_in_take |=>
        enc_valid && $rose(ser_tx_frame)) else $error("strobe answer");
    chk_frame_len: assert property ($rose(ser_tx_frame) |->
        ser_tx_frame [*8] ##1 !ser_tx_frame) else $error("frame length");
    chk_sign_first: assert property (lin_in_take && !enc_valid |=>
        ser_tx == enc_char[7]) else $error("first bit not sign");
    chk_enc_hold: assert property (enc_valid && !enc_ready |=>
        enc_valid && $stable(enc_char)) else $error("stalled word moved");
    chk_buf_level: assert property (enc_valid == (occ_r != 2'h0))
        else $error("buffer level");
    chk_dec_time: assert property ($fell(ser_rx_frame) &&
        rxn_r == 4'h8 |-> ##2 dec_valid) else $error("decode late");
    chk_dec_char: assert property (dec_valid |->
        dec_char == $past(rxs_r, 2)) else $error("rx bit order");
    chk_dec_pulse: assert property (dec_valid |=> !dec_valid)
        else $error("decode pulse long");
    chk_zero_gone: assert property (enc_valid && law_mu &&
        zero_sup && !path_alaw |-> enc_char != 8'h00) else $error("zero char");
    cover property (lin_in_take && enc_valid && !enc_ready);
    cover property (lin_in_take && seen_r && gap_r == GAP2);
    cover property (dec_valid && law_mu);
endmodule
bind pcm_compander compander_chk chk (.*);

/* compander_far.sv */
`timescale 1ns/1ps
module sample_path (
    // clock
    input wire logic ref_clk,
    // serial transmit path
    input wire logic ser_tx,
    input wire logic ser_tx_frame,
    // stream handshake
    input wire logic stall,
    output logic enc_ready,
    // assembled character
    output logic [7:0] got_char
);
    // ----------------------------------------
    // receiver of the serial path
    // ----------------------------------------
    assign enc_ready = !stall;
    always_ff @(posedge ref_clk) begin
        if (ser_tx_frame) begin
            got_char <= {got_char[6:0], ser_tx};
        end
    end
endmodule

/* compander_pkg.sv */
package compander_pkg;

    localparam int CLK_HZ = 125000000;
    localparam int SAMPLE_HZ = 8000;
    localparam int SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;
    localparam int CHAR_W = 8;
    localparam int LIN_W = 14;
    localparam int A_W = 13;
    localparam logic [7:0] A_INV_MASK = 8'h55;
    localparam logic [7:0] MU_ZERO_SUB = 8'h02;
    localparam logic [13:0] MU_BIAS = 14'h0021;
    localparam logic [13:0] MU_CLIP = 14'h1FDE;
    localparam logic [12:0] A_MAX = 13'h0FFF;

    typedef enum logic {LAW_A, LAW_MU} law_e;

    typedef struct packed {
        logic [CHAR_W-1:0] chr;
        logic [LIN_W-1:0] lin;
    } word_s;

endpackage

/* logarithmic_pcm_compander_bench.sv */
`timescale 1ns/1ps
module logarithmic_pcm_compander_bench;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic law_mu = 1'b0;
    logic zero_sup = 1'b0;
    logic path_alaw = 1'b0;
    logic [13:0] lin_in = 14'h0000;
    logic ser_rx = 1'b0;
    logic ser_rx_frame = 1'b0;
    logic stall = 1'b1;
    logic lin_in_take, ser_tx, ser_tx_frame, enc_valid, enc_ready, dec_valid;
    logic [7:0] enc_char, dec_char, got_char;
    logic [13:0] enc_lin, dec_lin;
    bit hit;
    int errors = 0;
    int comparisons = 0;
    // law nibble (bit0 mu, bit1 zero suppression), character, linear
    logic [27:0] rows [7] = '{28'h0D50001, 28'h0AA0FC0, 28'h0A50840,
        28'h02A3040, 28'h30222A1, 28'h1801F5F, 28'h1FF0000};
    always #4 ref_clk = ~ref_clk;
    pcm_compander dut (.ref_clk(ref_clk), .rst(rst), .law_mu(law_mu),
        .zero_sup(zero_sup), .path_alaw(path_alaw), .lin_in(lin_in),
        .lin_in_take(lin_in_take), .ser_tx(ser_tx),
        .ser_tx_frame(ser_tx_frame), .ser_rx(ser_rx),
        .ser_rx_frame(ser_rx_frame), .enc_valid(enc_valid),
        .enc_ready(enc_ready), .enc_char(enc_char), .enc_lin(enc_lin),
        .dec_valid(dec_valid), .dec_lin(dec_lin), .dec_char(dec_char));
    sample_path far (.ref_clk(ref_clk), .ser_tx(ser_tx),
        .ser_tx_frame(ser_tx_frame), .stall(stall),
        .enc_ready(enc_ready), .got_char(got_char));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        comparisons++;
        if (seen !== want) begin
            errors++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic test_done;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic send(input logic [7:0] c);
        for (int i = 7; i >= 0; i--) begin
            ser_rx_frame = 1'b1;
            ser_rx = c[i];
            step(1);
        end
        ser_rx_frame = 1'b0;
        ser_rx = ~c[0];
        for (int k = 0; k < 20 && dec_valid !== 1'b1; k++) begin
            step(1);
        end
        check(16'(dec_char), 16'(c));
    endtask
    task automatic wait_take;
        hit = 1'b0;
        for (int k = 0; k < 16000 && !hit; k++) begin
            step(1);
            hit = (lin_in_take === 1'b1);
        end
    endtask
    task automatic encode(input logic [13:0] lin, input logic [7:0] want);
        lin_in = lin;
        wait_take();
        check(16'(hit), 16'h0001);
        step(1);
        check(16'(enc_valid), 16'h0001);
        step(9);
        check(16'(got_char), 16'(want));
    endtask
    initial begin
        #720000;
        errors++;
        test_done();
    end
    initial begin
        step(16);
        check(16'(enc_valid), 16'h0000);
        check(16'(ser_tx_frame), 16'h0000);
        rst = 1'b0;
        foreach (rows[i]) begin
            law_mu = rows[i][24];
            zero_sup = rows[i][25];
            send(rows[i][23:16]);
            check(16'(dec_lin), rows[i][15:0]);
        end
        law_mu = 1'b0;
        zero_sup = 1'b0;
        // far side stalls through two strobes, the third must be lost
        encode(14'h0000, 8'hD5);
        encode(14'h0880, 8'hA4);
        wait_take();
        check(16'(hit), 16'h0000);
        check(16'(enc_char), 16'h00D5);
        stall = 1'b0;
        step(1);
        check(16'(enc_char), 16'h00A4);
        check(16'(enc_lin), 16'h0880);
        step(1);
        check(16'(enc_valid), 16'h0000);
        law_mu = 1'b1;
        zero_sup = 1'b1;
        encode(14'h2021, 8'h02);
        zero_sup = 1'b0;
        path_alaw = 1'b1;
        encode(14'h1F40, 8'hAA);
        test_done();
    end
endmodule

/* pcm_compander.sv */
`timescale 1ns/1ps
module pcm_compander (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // configuration levels
    input wire logic law_mu,
    input wire logic zero_sup,
    input wire logic path_alaw,
    // linear sample source
    input wire logic [13:0] lin_in,
    output logic lin_in_take,
    // serial transmit path
    output logic ser_tx,
    output logic ser_tx_frame,
    // serial receive path
    input wire logic ser_rx,
    input wire logic ser_rx_frame,
    // encoded characters out
    output logic enc_valid,
    input wire logic enc_ready,
    output logic [7:0] enc_char,
    output logic [13:0] enc_lin,
    // decoded samples out
    output logic dec_valid,
    output logic [13:0] dec_lin,
    output logic [7:0] dec_char
);
    // ----------------------------------------
    // conversion functions
    // ----------------------------------------
    function automatic logic [2:0] seg_of(input logic [12:0] v);
        logic [2:0] s;
        s = 3'h0;
        for (int i = 7; i >= 1; i--) begin
            if (s == 3'h0 && v[i+4]) begin
                s = 3'(i);
            end
        end
        return s;
    endfunction

    // lin is a 13-bit two's complement value in A-law scale
    function automatic logic [7:0] a_enc(input logic [12:0] lin);
        logic [12:0] mag;
        logic [2:0] s;
        logic [3:0] q;
        logic [7:0] raw;
        mag = lin[12] ? 13'(~lin) : lin;
        s = seg_of(mag);
        q = (s == 3'h0) ? mag[4:1] : 4'(mag >> s);
        raw = {~lin[12], s, q};
        return raw ^ compander_pkg::A_INV_MASK;
    endfunction

    function automatic logic [12:0] a_dec(input logic [7:0] chr);
        logic [7:0] raw;
        logic [12:0] mag;
        raw = chr ^ compander_pkg::A_INV_MASK;
        if (raw[6:4] == 3'h0) begin
            mag = {8'h00, raw[3:0], 1'b1};
        end else begin
            mag = 13'({7'h00, 1'b1, raw[3:0], 1'b1} << (raw[6:4] - 3'h1));
        end
        // true negation keeps the two polarities symmetric
        return raw[7] ? mag : 13'(13'h0000 - mag);
    endfunction

    // lin is a 14-bit two's complement value in mu-law scale
    function automatic logic [7:0] mu_enc(input logic [13:0] lin,
                                          input logic sup);
        logic [13:0] mag;
        logic [2:0] s;
        logic [7:0] c;
        mag = lin[13] ? 14'(~lin) : lin;
        if (mag > compander_pkg::MU_CLIP) begin
            mag = compander_pkg::MU_CLIP;
        end
        mag = mag + compander_pkg::MU_BIAS;
        // biased magnitude reaches bit 12, so look one bit higher
        s = seg_of(mag[13:1]);
        c = ~{lin[13], s, 4'(mag >> ({1'b0, s} + 4'h1))};
        if (sup && c == 8'h00) begin
            c = compander_pkg::MU_ZERO_SUB;
        end
        return c;
    endfunction

    function automatic logic [13:0] mu_dec(input logic [7:0] chr);
        logic [7:0] c;
        logic [13:0] mag;
        c = ~chr;
        mag = 14'(({1'b1, c[3:0], 1'b1} << c[6:4])
                  - compander_pkg::MU_BIAS);
        return c[7] ? 14'(14'h0000 - mag) : mag;
    endfunction

    // mu-law character to A-law character via the linear domain
    function automatic logic [7:0] mu_to_a(input logic [7:0] chr);
        logic [13:0] l;
        l = mu_dec(chr);
        return a_enc(l[13:1]);
    endfunction

    // ----------------------------------------
    // sample timing
    // ----------------------------------------
    logic [13:0] tick_r, tick_nxt;
    logic [13:0] lin_s1_r, lin_s2_r;
    // configuration pins are synchronised like the sample and serial receive pins
    logic law_s1_r, law_s2_r, sup_s1_r, sup_s2_r, alaw_s1_r, alaw_s2_r;
    logic buf_in_ready;
    logic strobe;
    assign strobe = (tick_r == 14'(compander_pkg::SAMPLE_CYC - 1));
    assign lin_in_take = strobe && buf_in_ready;

    always_comb begin
        tick_nxt = strobe ? 14'h0000 : tick_r + 14'h0001;
    end

    // ----------------------------------------
    // encoder into buffer
    // ----------------------------------------
    compander_pkg::word_s enc_word, buf_out;
    logic buf_out_valid;
    logic [7:0] chr_now;

    always_comb begin
        if (law_s2_r) begin
            chr_now = mu_enc(lin_s2_r, sup_s2_r);
            if (alaw_s2_r) begin
                chr_now = mu_to_a(chr_now);
            end
        end else begin
            chr_now = a_enc(lin_s2_r[12:0]);
        end
        enc_word.chr = chr_now;
        enc_word.lin = lin_s2_r;
    end

    skid_buf u_buf (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_valid(strobe),
        .in_ready(buf_in_ready),
        .in_data(enc_word),
        .out_valid(buf_out_valid),
        .out_ready(enc_ready),
        .out_data(buf_out)
    );
    assign enc_valid = buf_out_valid;
    assign enc_char = buf_out.chr;
    assign enc_lin = buf_out.lin;

    // ----------------------------------------
    // serial transmit, sign bit first
    // ----------------------------------------
    logic [7:0] tx_sh_r, tx_sh_nxt;
    logic [3:0] tx_cnt_r, tx_cnt_nxt;
    always_comb begin
        tx_sh_nxt = tx_sh_r;
        tx_cnt_nxt = tx_cnt_r;
        if (lin_in_take) begin
            tx_sh_nxt = chr_now;
            tx_cnt_nxt = 4'h8;
        end else if (tx_cnt_r != 4'h0) begin
            tx_sh_nxt = {tx_sh_r[6:0], 1'b0};
            tx_cnt_nxt = tx_cnt_r - 4'h1;
        end
    end
    assign ser_tx = tx_sh_r[7];
    assign ser_tx_frame = (tx_cnt_r != 4'h0);

    // ----------------------------------------
    // serial receive and decode
    // ----------------------------------------
    logic rx_s1_r, rx_s2_r, rf_s1_r, rf_s2_r;
    logic [7:0] rx_sh_r, rx_sh_nxt;
    logic [3:0] rx_cnt_r, rx_cnt_nxt;
    logic dv_nxt, dv_r;
    logic [13:0] dl_nxt, dl_r;
    logic [7:0] dc_nxt, dc_r;
    logic [7:0] rx_full;
    logic [12:0] a_lin;
    always_comb begin
        rx_sh_nxt = rx_sh_r;
        rx_cnt_nxt = rx_cnt_r;
        dv_nxt = 1'b0;
        dl_nxt = dl_r;
        dc_nxt = dc_r;
        rx_full = {rx_sh_r[6:0], rx_s2_r};
        a_lin = a_dec(rx_full);
        if (!rf_s2_r) begin
            rx_cnt_nxt = 4'h0;
        end else begin
            rx_sh_nxt = rx_full;
            rx_cnt_nxt = rx_cnt_r + 4'h1;
            if (rx_cnt_r == 4'h7) begin
                rx_cnt_nxt = 4'h0;
                dv_nxt = 1'b1;
                dc_nxt = rx_full;
                if (law_s2_r) begin
                    dl_nxt = mu_dec(rx_full);
                end else begin
                    dl_nxt = {a_lin[12], a_lin};
                end
            end
        end
    end
    assign dec_valid = dv_r;
    assign dec_lin = dl_r;
    assign dec_char = dc_r;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tick_r <= 14'h0000;
            lin_s1_r <= 14'h0000;
            lin_s2_r <= 14'h0000;
            law_s1_r <= 1'b0;
            law_s2_r <= 1'b0;
            sup_s1_r <= 1'b0;
            sup_s2_r <= 1'b0;
            alaw_s1_r <= 1'b0;
            alaw_s2_r <= 1'b0;
            tx_sh_r <= 8'h00;
            tx_cnt_r <= 4'h0;
            rx_s1_r <= 1'b0;
            rx_s2_r <= 1'b0;
            rf_s1_r <= 1'b0;
            rf_s2_r <= 1'b0;
            rx_sh_r <= 8'h00;
            rx_cnt_r <= 4'h0;
            dv_r <= 1'b0;
            dl_r <= 14'h0000;
            dc_r <= 8'h00;
        end else begin
            tick_r <= tick_nxt;
            lin_s1_r <= lin_in;
            lin_s2_r <= lin_s1_r;
            law_s1_r <= law_mu;
            law_s2_r <= law_s1_r;
            sup_s1_r <= zero_sup;
            sup_s2_r <= sup_s1_r;
            alaw_s1_r <= path_alaw;
            alaw_s2_r <= alaw_s1_r;
            tx_sh_r <= tx_sh_nxt;
            tx_cnt_r <= tx_cnt_nxt;
            rx_s1_r <= ser_rx;
            rx_s2_r <= rx_s1_r;
            rf_s1_r <= ser_rx_frame;
            rf_s2_r <= rf_s1_r;
            rx_sh_r <= rx_sh_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            dv_r <= dv_nxt;
            dl_r <= dl_nxt;
            dc_r <= dc_nxt;
        end
    end
endmodule

/* skid_buf.sv */
`timescale 1ns/1ps
// ----------------------------------------
// two-entry buffer: a receiver stall loses no word until both entries are full
// ----------------------------------------
module skid_buf (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire compander_pkg::word_s in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output compander_pkg::word_s out_data
);
    compander_pkg::word_s mem_r [2];
    compander_pkg::word_s mem_nxt [2];
    logic [1:0] cnt_r, cnt_nxt;
    logic rd_r, rd_nxt, wr_r, wr_nxt;
    logic push, pop;

    assign in_ready = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data = mem_r[rd_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        mem_nxt = mem_r;
        rd_nxt = rd_r;
        wr_nxt = wr_r;
        cnt_nxt = cnt_r;
        if (push) begin
            mem_nxt[wr_r] = in_data;
            wr_nxt = ~wr_r;
        end
        if (pop) begin
            rd_nxt = ~rd_r;
        end
        if (push && !pop) begin
            cnt_nxt = cnt_r + 2'h1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 2'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mem_r[0] <= '0;
            mem_r[1] <= '0;
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            mem_r <= mem_nxt;
            rd_r <= rd_nxt;
            wr_r <= wr_nxt;
            cnt_r <= cnt_nxt;
        end
    end
endmodule
